//--- inc/lms_pkg.sv
// Purpose: shared constants and types of the lcd mode select and register block
// Assumes: avalon-mm byte addresses, 32-bit data words
// Notes:   select vector order is {dual, graphic, eight-bit, wide, attribute}
package lms_pkg;

    // register index space
    localparam int unsigned IDX_W      = 5;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NUM_IDX    = 32;
    localparam logic [4:0]  IDX_RESET  = 5'h00;
    localparam logic [4:0]  IDX_MODE   = 5'h16;
    // one bit per index: 0,1,9-15,18-22 exist, the rest are holes
    localparam logic [31:0] IDX_IMPL   = 32'h007cfe03;

    // avalon byte offsets
    localparam int unsigned ADDR_W     = 4;
    localparam logic [3:0]  OFS_INDEX  = 4'h0;
    localparam logic [3:0]  OFS_DATA   = 4'h4;
    localparam logic [3:0]  OFS_STATUS = 4'h8;

    // mode bits register fields
    localparam int unsigned MB_ATTR    = 0;
    localparam int unsigned MB_WIDE    = 2;
    localparam int unsigned MB_GRAPH   = 3;

    // select vector positions
    localparam int unsigned SEL_W      = 5;
    localparam int unsigned SEL_ATTR   = 0;
    localparam int unsigned SEL_WIDE   = 1;
    localparam int unsigned SEL_XFER8  = 2;
    localparam int unsigned SEL_GRAPH  = 3;
    localparam int unsigned SEL_DUAL   = 4;

    // mode numbers
    localparam logic [3:0]  MODE_NONE  = 4'h0;
    localparam logic [3:0]  MODE_DCHR  = 4'h1;
    localparam logic [3:0]  MODE_DWIDE = 4'h2;
    localparam logic [3:0]  MODE_DG1   = 4'h3;
    localparam logic [3:0]  MODE_DG2   = 4'h4;
    localparam logic [3:0]  MODE_SCHR  = 4'h5;
    localparam logic [3:0]  MODE_SWIDE = 4'h6;
    localparam logic [3:0]  MODE_SG1   = 4'h7;
    localparam logic [3:0]  MODE_SG2   = 4'h8;
    localparam logic [3:0]  MODE_8CHR  = 4'h9;
    localparam logic [3:0]  MODE_8WIDE = 4'ha;
    localparam logic [3:0]  MODE_8G1   = 4'hb;
    localparam logic [3:0]  MODE_8G2   = 4'hc;
    localparam logic [3:0]  MODE_LARGE = 4'hd;

    // data rates in mbit/s
    localparam logic [7:0]  RATE_WIDE  = 8'h0a;
    localparam logic [7:0]  RATE_NORM  = 8'h14;
    localparam logic [7:0]  RATE_LARGE = 8'h28;

    // status word fields
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_VALID    = 4;
    localparam int unsigned ST_DUAL     = 5;
    localparam int unsigned ST_XFER8    = 6;
    localparam int unsigned ST_CHAR     = 7;
    localparam int unsigned ST_G1       = 8;
    localparam int unsigned ST_G2       = 9;
    localparam int unsigned ST_WIDE     = 10;
    localparam int unsigned ST_ATTR     = 11;
    localparam int unsigned ST_ORMERGE  = 12;
    localparam int unsigned ST_LARGE    = 13;
    localparam int unsigned ST_MEMRATE  = 16;
    localparam int unsigned ST_LCDRATE  = 24;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_BUSY = 3'b010,
        BUS_ACK  = 3'b100
    } lms_bus_state_type;

endpackage

//--- hw/lms_reg_mem.sv
// Purpose: small register file holding the data registers
// Assumes: one write port, one read port, same clock
// Notes:   contents survive reset, read data come from a register
`timescale 1ns/1ps
`default_nettype none
module lms_reg_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] store_ff [DEPTH];
    logic [WIDTH-1:0] rdData_ff;

    // reset does not touch contents, software reprograms after power up
    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            store_ff[wrAddr] <= wrData;
        end
        rdData_ff <= store_ff[rdAddr];
    end

    assign rdData = rdData_ff;

endmodule // lms_reg_mem
`default_nettype wire

//--- hw/lms_mode_regs.sv
// Purpose: display mode selection and indexed register access for an lcd timing controller
// Assumes: select pins are asynchronous, software on avalon-mm with waitrequest
// Notes:   index at 0x0, data port at 0x4, decoded mode status at 0x8
//
// Notes on behaviour
// - panel arrangement single or dual is fixed before display is driven.
// - an eight-bit lcd data output exists besides the four-bit one.
// - dual high gives two 4-bit outputs; else one 4- or 8-bit output.
// - graphic high: attribute high is graphic 1, low graphic 2, wide low.
// - wide select acts only in character format, giving double-width characters.
// - in character format attribute high uses attributes, low OR-merges data.
// - mode 13: dual, graphic, eight-bit, attribute high, wide low, 40 mbit/s.
// - memory read rate 20 mbit/s normally, 10 mbit/s in wide character.
// - wide character modes send lcd data at twice the read rate, 20.
// - graphic, wide, attribute are pin OR mode bit; dual, eight-bit pins only.
// - one index register plus fourteen data registers chosen by index.
// - data port reads and writes reach the register the index names.
// - indices 2 to 8, 16 and 17 are unimplemented.
// - wide ORs with mode bit 2, attribute with mode bit 0.
// - index written with register select low; unimplemented index ignored.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lms_mode_regs
(
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    // select pins
    input  wire logic                       dualSelect,
    input  wire logic                       graphicSelect,
    input  wire logic                       eight_bit_xfer_select,
    input  wire logic                       wideSelect,
    input  wire logic                       attribute_select,
    // avalon-mm slave
    input  wire logic [lms_pkg::ADDR_W-1:0] address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    output logic      [31:0]                readdata,
    output logic                            waitrequest,
    // decoded configuration
    output logic [3:0]                      modeNumber,
    output logic                            modeValid,
    output logic                            dualPanel,
    output logic                            lcdData8,
    output logic                            charFormat,
    output logic                            graphic1,
    output logic                            graphic2,
    output logic                            wideDisplay,
    output logic                            attributeMode,
    output logic                            orMerge,
    output logic                            largeScreen,
    output logic [7:0]                      memRateMbps,
    output logic [7:0]                      lcdRateMbps
);
    import lms_pkg::*;

    logic [SEL_W-1:0]  selMeta_ff, selSync_ff;
    logic [SEL_W-1:0]  effSel;
    logic              selLegal;
    lms_bus_state_type state_ff, nxt_state;
    logic [IDX_W-1:0]  register_index_ff, nxt_register_index;
    logic [2:0]        modeBits_ff, nxt_modeBits;
    logic [31:0]       readdata_ff, nxt_readdata;
    logic              waitrequest_ff, nxt_waitrequest;
    logic              memWe;
    logic [DATA_W-1:0] memRd;
    logic [3:0]        mode_ff, nxt_mode;
    logic              valid_ff, nxt_valid;
    logic [31:0]       status_ff, nxt_status;
    logic              attrHeld_ff, nxt_attrHeld;
    logic              decG1, decG2, decWide, decChar, decLarge;
    logic              idxWrite, idxOk;

    // two-flop synchroniser on the select pins
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            selMeta_ff <= '0;
            selSync_ff <= '0;
        end
        else
        begin
            selMeta_ff <= {dualSelect, graphicSelect, eight_bit_xfer_select,
                           wideSelect, attribute_select};
            selSync_ff <= selMeta_ff;
        end
    end

    // effective selects
    always_comb
    begin
        effSel            = selSync_ff;
        effSel[SEL_GRAPH] = selSync_ff[SEL_GRAPH] | modeBits_ff[2];
        effSel[SEL_WIDE]  = selSync_ff[SEL_WIDE]  | modeBits_ff[1];
        effSel[SEL_ATTR]  = selSync_ff[SEL_ATTR]  | modeBits_ff[0];
    end

    // select combination to mode number; {dual,graph,xfer8,wide,attr}
    always_comb
    begin
        selLegal = 1'b1;
        nxt_mode = MODE_NONE;
        unique case (effSel)
            5'h10, 5'h11: nxt_mode = MODE_DCHR;
            5'h12, 5'h13: nxt_mode = MODE_DWIDE;
            5'h19:        nxt_mode = MODE_DG1;
            5'h18:        nxt_mode = MODE_DG2;
            5'h00, 5'h01: nxt_mode = MODE_SCHR;
            5'h02, 5'h03: nxt_mode = MODE_SWIDE;
            5'h09:        nxt_mode = MODE_SG1;
            5'h08:        nxt_mode = MODE_SG2;
            5'h04, 5'h05: nxt_mode = MODE_8CHR;
            5'h06, 5'h07: nxt_mode = MODE_8WIDE;
            5'h0d:        nxt_mode = MODE_8G1;
            5'h0c:        nxt_mode = MODE_8G2;
            5'h1d:        nxt_mode = MODE_LARGE;
            default:      selLegal = 1'b0;
        endcase
        // a forbidden combination keeps the last good configuration
        if (!selLegal)
        begin
            nxt_mode = mode_ff;
        end
        nxt_valid = selLegal;
    end

    // mode and its decoded flags register together, so outputs never glitch
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            mode_ff     <= MODE_NONE;
            valid_ff    <= 1'b0;
            attrHeld_ff <= 1'b0;
            status_ff   <= {RATE_NORM, RATE_NORM, 16'h0000};
        end
        else
        begin
            mode_ff     <= nxt_mode;
            valid_ff    <= nxt_valid;
            attrHeld_ff <= nxt_attrHeld;
            status_ff   <= nxt_status;
        end
    end

    // bus side decode
    always_comb
    begin
        idxWrite = write && (address == OFS_INDEX);
        idxOk    = (writedata[31:IDX_W] == '0) && IDX_IMPL[writedata[IDX_W-1:0]];
        memWe    = (state_ff == BUS_IDLE) && write && (address == OFS_DATA);
    end

    // status word decoded from the next mode; attribute choice held with it
    always_comb
    begin
        nxt_attrHeld = selLegal ? effSel[SEL_ATTR] : attrHeld_ff;
        decG1        = (nxt_mode == MODE_DG1 || nxt_mode == MODE_SG1 || nxt_mode == MODE_8G1
                        || nxt_mode == MODE_LARGE);
        decG2        = (nxt_mode == MODE_DG2 || nxt_mode == MODE_SG2
                        || nxt_mode == MODE_8G2);
        decWide      = (nxt_mode == MODE_DWIDE || nxt_mode == MODE_SWIDE
                        || nxt_mode == MODE_8WIDE);
        decLarge     = (nxt_mode == MODE_LARGE);
        decChar      = (nxt_mode != MODE_NONE) && !decG1 && !decG2;
        nxt_status                   = '0;
        nxt_status[ST_MODE_LSB +: 4] = nxt_mode;
        nxt_status[ST_VALID]         = nxt_valid;
        nxt_status[ST_DUAL]          = (nxt_mode >= MODE_DCHR && nxt_mode <= MODE_DG2)
                                       || decLarge;
        nxt_status[ST_XFER8]         = (nxt_mode >= MODE_8CHR && nxt_mode <= MODE_8G2);
        nxt_status[ST_CHAR]          = decChar;
        nxt_status[ST_G1]            = decG1;
        nxt_status[ST_G2]            = decG2;
        nxt_status[ST_WIDE]          = decWide;
        nxt_status[ST_ATTR]          = decChar && nxt_attrHeld;
        nxt_status[ST_ORMERGE]       = decChar && !nxt_attrHeld;
        nxt_status[ST_LARGE]         = decLarge;
        nxt_status[ST_MEMRATE +: 8]  = decLarge ? RATE_LARGE
                                       : (decWide ? RATE_WIDE : RATE_NORM);
        nxt_status[ST_LCDRATE +: 8]  = decLarge ? RATE_LARGE : RATE_NORM;
    end

    // bus state machine: take, read memory, answer; three edges per access
    always_comb
    begin
        nxt_state          = state_ff;
        nxt_register_index = register_index_ff;
        nxt_modeBits       = modeBits_ff;
        nxt_readdata       = readdata_ff;
        nxt_waitrequest    = 1'b1;
        unique case (state_ff)
            BUS_IDLE:
            begin
                if (read || write)
                begin
                    nxt_state = BUS_BUSY;
                end
                if (idxWrite && idxOk)
                begin
                    nxt_register_index = writedata[IDX_W-1:0];
                end
                if (memWe && (register_index_ff == IDX_MODE))
                begin
                    nxt_modeBits = {writedata[MB_GRAPH], writedata[MB_WIDE],
                                    writedata[MB_ATTR]};
                end
            end
            BUS_BUSY:
            begin
                nxt_state       = BUS_ACK;
                nxt_waitrequest = 1'b0;
                nxt_readdata    = '0;
                if (read)
                begin
                    unique case (address)
                        OFS_INDEX:  nxt_readdata[IDX_W-1:0]  = register_index_ff;
                        OFS_DATA:   nxt_readdata[DATA_W-1:0] = memRd;
                        OFS_STATUS: nxt_readdata             = status_ff;
                        default:    nxt_readdata             = '0;
                    endcase
                end
            end
            BUS_ACK:
            begin
                nxt_state = BUS_IDLE;
            end
            default:
            begin
                nxt_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_ff          <= BUS_IDLE;
            register_index_ff <= IDX_RESET;
            modeBits_ff       <= '0;
            readdata_ff       <= '0;
            waitrequest_ff    <= 1'b1;
        end
        else
        begin
            state_ff          <= nxt_state;
            register_index_ff <= nxt_register_index;
            modeBits_ff       <= nxt_modeBits;
            readdata_ff       <= nxt_readdata;
            waitrequest_ff    <= nxt_waitrequest;
        end
    end

    // data registers; holes never become the index so are never touched
    lms_reg_mem #(
        .WIDTH (DATA_W),
        .DEPTH (NUM_IDX),
        .AW    (IDX_W)
    ) u_mem (
        .ref_clk (ref_clk),
        .wrEn    (memWe),
        .wrAddr  (register_index_ff),
        .wrData  (writedata[DATA_W-1:0]),
        .rdAddr  (register_index_ff),
        .rdData  (memRd)
    );

    // outputs are plain flop taps
    assign modeNumber    = mode_ff;
    assign modeValid     = valid_ff;
    assign dualPanel     = status_ff[ST_DUAL];
    assign lcdData8      = status_ff[ST_XFER8];
    assign wideDisplay   = status_ff[ST_WIDE];
    assign graphic1      = status_ff[ST_G1];
    assign graphic2      = status_ff[ST_G2];
    assign charFormat    = status_ff[ST_CHAR];
    assign largeScreen   = status_ff[ST_LARGE];
    assign attributeMode = status_ff[ST_ATTR];
    assign orMerge       = status_ff[ST_ORMERGE];
    assign memRateMbps   = status_ff[ST_MEMRATE +: 8];
    assign lcdRateMbps   = status_ff[ST_LCDRATE +: 8];
    assign readdata      = readdata_ff;
    assign waitrequest   = waitrequest_ff;

    // checks
    property p_answer_timing;
        @(posedge ref_clk) disable iff (!nrst)
        (state_ff == BUS_IDLE && (read || write)) |=> waitrequest ##1 !waitrequest;
    endproperty
    a_answer_timing: assert property (p_answer_timing) else $error("answer not two edges after take");

    property p_index_taken;
        @(posedge ref_clk) disable iff (!nrst)
        (state_ff == BUS_IDLE && idxWrite && idxOk) |=> register_index_ff == $past(writedata[4:0]);
    endproperty
    a_index_taken: assert property (p_index_taken) else $error("index write lost");

    property p_index_hole;
        @(posedge ref_clk) disable iff (!nrst)
        (idxWrite && !idxOk) |=> $stable(register_index_ff);
    endproperty
    a_index_hole: assert property (p_index_hole) else $error("hole index accepted");

    property p_graphic_plain;
        @(posedge ref_clk) disable iff (!nrst)
        (graphic1 || graphic2) |-> !wideDisplay && !attributeMode && !orMerge;
    endproperty
    a_graphic_plain: assert property (p_graphic_plain) else $error("graphic with char options");

    property p_large;
        @(posedge ref_clk) disable iff (!nrst)
        largeScreen |-> dualPanel && graphic1 && memRateMbps == 8'h28;
    endproperty
    a_large: assert property (p_large) else $error("large screen config wrong");

    property p_wide_rates;
        @(posedge ref_clk) disable iff (!nrst)
        wideDisplay |-> memRateMbps == 8'h0a && lcdRateMbps == 8'h14;
    endproperty
    a_wide_rates: assert property (p_wide_rates) else $error("wide rates wrong");

    property p_graphic_bit;
        @(posedge ref_clk) disable iff (!nrst)
        ($past(modeBits_ff[2]) && modeValid) |-> !charFormat;
    endproperty
    a_graphic_bit: assert property (p_graphic_bit) else $error("mode bit 3 not ORed");

    property p_hold_bad;
        @(posedge ref_clk) disable iff (!nrst)
        !selLegal |=> $stable(modeNumber) && !modeValid;
    endproperty
    a_hold_bad: assert property (p_hold_bad) else $error("forbidden combo changed mode");

    property p_xfer8_single;
        @(posedge ref_clk) disable iff (!nrst)
        lcdData8 |-> !dualPanel;
    endproperty
    a_xfer8_single: assert property (p_xfer8_single) else $error("eight-bit with dual");

    c_large:   cover property (@(posedge ref_clk) disable iff (!nrst) largeScreen);
    c_wide_at: cover property (@(posedge ref_clk) disable iff (!nrst) wideDisplay && attributeMode);
    c_bad:     cover property (@(posedge ref_clk) disable iff (!nrst) !selLegal);
    c_rd_data: cover property (@(posedge ref_clk) disable iff (!nrst)
                               read && address == OFS_DATA && !waitrequest);

endmodule // lms_mode_regs
`default_nettype wire

//--- verification/lms_pin_model.sv
// Purpose: model of the board strapping that drives the five mode select pins
// Assumes: bench hands over a combination, pins follow it one edge later
// Notes:   pins move together, so no stray combination is ever seen between two
`timescale 1ns/1ps
`default_nettype none
module lms_pin_model
(
    input  wire logic       ref_clk,
    input  wire logic [4:0] combo,
    output var  logic       dualSelect,
    output var  logic       graphicSelect,
    output var  logic       eight_bit_xfer_select,
    output var  logic       wideSelect,
    output var  logic       attribute_select
);
    // only the combination the bench commands is applied, a bad one is cured by a new one
    always_ff @(posedge ref_clk)
    begin
        {dualSelect, graphicSelect, eight_bit_xfer_select, wideSelect, attribute_select} <= combo;
    end
endmodule // lms_pin_model
`default_nettype wire

//--- verification/lms_mode_regs_tb.sv
// Purpose: self-checking bench of the lcd mode select and register block
// Assumes: select pins come from the pin model, software speaks avalon-mm
// Notes:   data registers are not reset, so each one is written before it is read
`timescale 1ns/1ps
`default_nettype none
module lms_mode_regs_tb;
    import lms_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic [4:0]  combo     = 5'h00;
    logic [3:0]  address   = 4'h0;
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic        waitrequest, dualSelect, graphicSelect, eight_bit_xfer_select;
    logic        wideSelect, attribute_select, modeValid, dualPanel, lcdData8;
    logic        charFormat, graphic1, graphic2, wideDisplay, attributeMode;
    logic        orMerge, largeScreen;
    logic [3:0]  modeNumber;
    logic [7:0]  memRateMbps, lcdRateMbps;
    int          nMismatch = 0;
    int          compares  = 0;
    int          cycles    = 0;
    // {select pins, mode number} for every legal combination
    localparam logic [8:0] MODE_TAB [19] = '{9'h101, 9'h111, 9'h122, 9'h132, 9'h193, 9'h184,
        9'h005, 9'h015, 9'h026, 9'h036, 9'h097, 9'h088, 9'h049, 9'h059, 9'h06a, 9'h07a,
        9'h0db, 9'h0cc, 9'h1dd};

    always #2 ref_clk = ~ref_clk;

    lms_pin_model pin_u (.ref_clk(ref_clk), .combo(combo), .dualSelect(dualSelect),
        .graphicSelect(graphicSelect), .eight_bit_xfer_select(eight_bit_xfer_select),
        .wideSelect(wideSelect), .attribute_select(attribute_select));

    lms_mode_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .dualSelect(dualSelect),
        .graphicSelect(graphicSelect), .eight_bit_xfer_select(eight_bit_xfer_select),
        .wideSelect(wideSelect), .attribute_select(attribute_select), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .modeNumber(modeNumber), .modeValid(modeValid),
        .dualPanel(dualPanel), .lcdData8(lcdData8), .charFormat(charFormat),
        .graphic1(graphic1), .graphic2(graphic2), .wideDisplay(wideDisplay),
        .attributeMode(attributeMode), .orMerge(orMerge), .largeScreen(largeScreen),
        .memRateMbps(memRateMbps), .lcdRateMbps(lcdRateMbps));

    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a hung handshake must not stall the run forever
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            nMismatch++;
            $display("unexpected cycle count expected below 5000 seen 5000");
            printVerdict();
        end
    end

    task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic busXfer(input logic rdNwr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        read      <= rdNwr;
        write     <= !rdNwr;
        do
        begin
            @(posedge ref_clk);
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic regWr(input logic [4:0] idx, input logic [7:0] v);
        busXfer(1'b0, OFS_INDEX, {27'h0, idx});
        busXfer(1'b0, OFS_DATA, {24'h0, v});
    endtask

    function automatic logic [3:0] modeOf(input logic [4:0] s);
        foreach (MODE_TAB[i])
            if (MODE_TAB[i][8:4] == s) return MODE_TAB[i][3:0];
        return 4'h0;
    endfunction

    // status word worked out from the select combination
    function automatic logic [31:0] expStatus(input logic [4:0] s);
        logic        g, a, w, lg;
        logic [31:0] v;
        g = s[SEL_GRAPH];
        a = s[SEL_ATTR];
        w = !g && s[SEL_WIDE];
        lg = (modeOf(s) == MODE_LARGE);
        v = 32'h0;
        v[3:0] = modeOf(s);
        v[ST_VALID] = 1'b1;
        v[ST_DUAL] = s[SEL_DUAL];
        v[ST_XFER8] = s[SEL_XFER8] && !s[SEL_DUAL];
        {v[ST_CHAR], v[ST_G1], v[ST_G2], v[ST_WIDE]} = {!g, g && a, g && !a, w};
        {v[ST_ATTR], v[ST_ORMERGE], v[ST_LARGE]} = {!g && a, !g && !a, lg};
        v[23:16] = w ? 8'h0a : (lg ? 8'h28 : 8'h14);
        v[31:24] = lg ? 8'h28 : 8'h14;
        return v;
    endfunction

    // the designer's note gives two edges of pin sync and one of decode, plus one of the pin model
    task automatic checkMode(input logic [4:0] s);
        logic [31:0] e;
        e = expStatus(s);
        repeat (6) @(posedge ref_clk);
        busXfer(1'b1, OFS_STATUS, 32'h0);
        chkWord("status word", e, rd);
        chkWord("decoded flags", {18'h0, e[13:0]}, {18'h0, largeScreen, orMerge, attributeMode,
            wideDisplay, graphic2, graphic1, charFormat, lcdData8, dualPanel, modeValid,
            modeNumber});
        chkWord("rates", {16'h0, e[31:16]}, {16'h0, lcdRateMbps, memRateMbps});
    endtask

    initial
    begin
        logic [7:0] mb [8];
        logic [31:0] bad [6];
        mb = '{8'h08, 8'h09, 8'h04, 8'h05, 8'h01, 8'h12, 8'h16, 8'h00};
        bad = '{32'h2, 32'h8, 32'h10, 32'h17, 32'h1f, 32'h29};
        repeat (9) @(posedge ref_clk);
        chkWord("reset outputs", 32'h14140020, {lcdRateMbps, memRateMbps, 10'h0, waitrequest,
            modeValid, modeNumber});
        @(posedge ref_clk);
        nrst <= 1'b1;
        $display("test reset done");
        // every legal pin combination
        foreach (MODE_TAB[i])
        begin
            combo <= MODE_TAB[i][8:4];
            checkMode(MODE_TAB[i][8:4]);
        end
        $display("test mode table done");
        // illegal combinations keep the last mode, a legal one recovers
        foreach (bad[i])
        begin
            combo <= bad[i][4:0] | 5'h0a; // graphic with wide is never legal
            repeat (6) @(posedge ref_clk);
            chkWord("held mode", 32'h0000000d, {27'h0, modeValid, modeNumber});
        end
        combo <= 5'h00;
        checkMode(5'h00);
        $display("test forbidden combination done");
        // mode bits or-ed with the pins; bits 4 and 1 must not reach dual or eight-bit
        foreach (mb[i])
        begin
            regWr(IDX_MODE, mb[i]);
            checkMode({1'b0, mb[i][MB_GRAPH], 1'b0, mb[i][MB_WIDE], mb[i][MB_ATTR]});
        end
        combo <= 5'h10;
        regWr(IDX_MODE, 8'h09);
        checkMode(5'h19);
        regWr(IDX_MODE, 8'h00);
        combo <= 5'h00;
        $display("test mode bits done");
        // every implemented data register below index 22 holds its own value
        for (int i = 0; i < 22; i++)
            if (!(i inside {[2:8], 16, 17})) regWr(5'(i), 8'(i * 9 + 1));
        for (int i = 0; i < 22; i++)
            if (!(i inside {[2:8], 16, 17}))
            begin
                busXfer(1'b0, OFS_INDEX, 32'(i));
                busXfer(1'b1, OFS_DATA, 32'h0);
                chkWord("data register", 32'(i * 9 + 1), {24'h0, rd[7:0]});
            end
        // an index naming no register leaves the previous choice in place
        foreach (bad[i])
        begin
            busXfer(1'b0, OFS_INDEX, 32'h9);
            busXfer(1'b0, OFS_INDEX, (i < 3) ? bad[i] : bad[i] + 32'h20);
            busXfer(1'b1, OFS_DATA, 32'h0);
            chkWord("ignored index", 32'h52, {24'h0, rd[7:0]});
        end
        busXfer(1'b1, OFS_INDEX, 32'h0);
        chkWord("index readback", 32'h9, rd);
        busXfer(1'b0, 4'hc, 32'hff);
        busXfer(1'b1, 4'hc, 32'h0);
        chkWord("unmapped read", 32'h0, rd);
        $display("test registers done");
        printVerdict();
    end
endmodule // lms_mode_regs_tb
`default_nettype wire
